// ==== rtl/capture_regs.vh ====
// Constants of the sensor capture front end: limits, field positions,
// component codes, the warm-up count and the sampler width.
// Assumes inclusion by bare name from the design files of this block.
`ifndef CAPTURE_REGS_VH
`define CAPTURE_REGS_VH

// ****************************************************************
// Frame size limits in pixels and lines
// ****************************************************************
`define FRAME_MAX_W        10'h280
`define FRAME_MAX_H        10'h1e0
`define FRAME_MIN_W        10'h140
`define FRAME_MIN_H        10'h0f0
`define FRAME_MIN_H_SCALED 10'h100
`define GRAIN_MASK         10'h00f
`define GRAIN_MASK_SCALED  10'h01f

// ****************************************************************
// Embedded timing code layout
// ****************************************************************
`define CODE_LEAD0   8'hff
`define CODE_LEAD1   8'h00
`define CODE_V_BIT   5
`define CODE_H_BIT   4

// ****************************************************************
// Output component tags
// ****************************************************************
`define COMP_Y       2'h0
`define COMP_CB      2'h1
`define COMP_CR      2'h2

// ****************************************************************
// Warm-up count and sampler width
// ****************************************************************
`define PCLK_WARMUP  2'h3
`define SYNC_WIDTH   11

`endif

// ==== rtl/sync_sampler.v ====
// Two-stage synchroniser for a group of pins from outside the clock domain.
// Assumes each bit is a slow level; no bit relation is kept between stages.
module sync_sampler #(
  parameter W = 1
) (
  input  wire         clock,
  input  wire         rstn,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_reg;
  reg [W-1:0] stable_reg;

  // ****************************************************************
  // Two flip-flops, the first read only by the second
  // ****************************************************************
  always @(posedge clock) begin
    if (!rstn) begin
      meta_reg   <= {W{1'b0}};
      stable_reg <= {W{1'b0}};
    end else begin
      meta_reg   <= async_in;
      stable_reg <= meta_reg;
    end
  end

  assign sync_out = stable_reg;

endmodule // sync_sampler

// ==== rtl/code_finder.v ====
// Finds four-byte embedded timing codes in the sampled pixel byte stream.
// Assumes one strobe per sensor byte; delays pixels by three bytes so the
// code lead bytes never leak out as pixels.
`include "capture_regs.vh"
module code_finder (
  input  wire       clock,
  input  wire       rstn,
  input  wire       enable,
  input  wire       byte_stb,
  input  wire [7:0] byte_in,
  output reg        out_stb,
  output reg  [7:0] out_byte,
  output reg        out_line,
  output reg        code_stb,
  output reg        code_v,
  output reg        code_h
);

  reg [7:0] b0_reg;
  reg [7:0] b1_reg;
  reg [7:0] b2_reg;
  reg [2:0] keep_reg;
  reg [2:0] tag_reg;
  reg       line_on_reg;
  wire      lead_seen;

  // Three held bytes form FF 00 00 and all are real stream bytes
  assign lead_seen = (b2_reg == `CODE_LEAD0) && (b1_reg == `CODE_LEAD1) &&
                     (b0_reg == `CODE_LEAD1) && (keep_reg == 3'h7);

  // ****************************************************************
  // Delay line, code decode and line state
  // ****************************************************************
  always @(posedge clock) begin
    if (!rstn || !enable) begin
      b0_reg      <= 8'h00;
      b1_reg      <= 8'h00;
      b2_reg      <= 8'h00;
      keep_reg    <= 3'h0;
      tag_reg     <= 3'h0;
      line_on_reg <= 1'b0;
      out_stb     <= 1'b0;
      out_byte    <= 8'h00;
      out_line    <= 1'b0;
      code_stb    <= 1'b0;
      code_v      <= 1'b0;
      code_h      <= 1'b0;
    end else begin
      out_stb  <= 1'b0;
      code_stb <= 1'b0;
      if (byte_stb) begin
        if (lead_seen) begin
          // Fourth byte: only bits 5 and 4 matter
          code_stb    <= 1'b1;
          code_v      <= byte_in[`CODE_V_BIT];
          code_h      <= byte_in[`CODE_H_BIT];
          line_on_reg <= ~byte_in[`CODE_H_BIT];
          keep_reg    <= 3'h0;
        end else begin
          out_stb  <= keep_reg[2];
          out_byte <= b2_reg;
          out_line <= tag_reg[2];
          b2_reg   <= b1_reg;
          b1_reg   <= b0_reg;
          b0_reg   <= byte_in;
          keep_reg <= {keep_reg[1:0], 1'b1};
          tag_reg  <= {tag_reg[1:0], line_on_reg};
        end
      end
    end
  end

endmodule // code_finder

// ==== rtl/sensor_capture.v ====
// Sensor capture front end: samples an 8-bit sensor stream, frames it from
// reference pins or embedded codes, crops, tags components and counts frames.
// Assumes the sensor pins arrive asynchronously and the pixel clock is
// much slower than clock, so every pixel clock level is seen.
`include "capture_regs.vh"
module sensor_capture (
  input  wire       clock,
  input  wire       rstn,
  input  wire       pix_clk,
  input  wire [7:0] pix_data,
  input  wire       href,
  input  wire       vref,
  input  wire       capture_en,
  input  wire       embedded_mode,
  input  wire       scaler_en,
  input  wire       swap_chroma,
  input  wire       swap_luma_chroma,
  input  wire       mono_y_only,
  input  wire       mono_drop_chroma,
  input  wire       limited_mode,
  input  wire [5:0] frame_num,
  input  wire [5:0] frame_skip,
  input  wire [9:0] crop_x,
  input  wire [9:0] crop_w,
  input  wire [9:0] crop_y,
  input  wire [9:0] crop_h,
  output reg  [7:0] pix_out,
  output reg        pix_valid,
  output reg  [1:0] pix_comp,
  output reg        frame_start,
  output reg        frame_done,
  output reg        capture_active,
  output reg        capture_stopped,
  output reg  [5:0] frame_total,
  output reg        size_error
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Position inside a window whose length is capped at a limit
  function in_window;
    input [10:0] pos;
    input [9:0]  start;
    input [9:0]  len;
    input [9:0]  lim;
    reg   [10:0] span;
    begin
      span      = (len > lim) ? {1'b0, lim} : {1'b0, len};
      in_window = (pos >= {1'b0, start}) &&
                  ((pos - {1'b0, start}) < span);
    end
  endfunction

  // Frame size legal for the current scaler setting
  function size_ok;
    input [9:0] w;
    input [9:0] h;
    input       scaled;
    reg   [9:0] mask;
    reg   [9:0] min_h;
    begin
      mask    = scaled ? `GRAIN_MASK_SCALED : `GRAIN_MASK;
      min_h   = scaled ? `FRAME_MIN_H_SCALED : `FRAME_MIN_H;
      size_ok = (w >= `FRAME_MIN_W) && (w <= `FRAME_MAX_W) &&
                (h >= min_h) && (h <= `FRAME_MAX_H) &&
                ((w & mask) == 10'h000) && ((h & mask) == 10'h000);
    end
  endfunction

  // ****************************************************************
  // Pin sampling and pixel clock edge detection
  // ****************************************************************
  wire [`SYNC_WIDTH-1:0] sync_bus;
  wire                   s_pclk;
  wire                   s_href;
  wire                   s_vref;
  wire [7:0]             s_data;
  reg                    pclk_d_reg;
  reg                    href_d_reg;
  reg                    vref_d_reg;
  reg  [1:0]             warm_reg;
  wire                   pix_edge;
  wire                   warm;

  // All sensor pins pass two flip-flops before use
  sync_sampler #(
    .W (`SYNC_WIDTH)
  ) u_sync (
    .clock    (clock),
    .rstn     (rstn),
    .async_in ({pix_clk, href, vref, pix_data}),
    .sync_out (sync_bus)
  );

  assign s_pclk   = sync_bus[10];
  assign s_href   = sync_bus[9];
  assign s_vref   = sync_bus[8];
  assign s_data   = sync_bus[7:0];
  assign pix_edge = s_pclk & ~pclk_d_reg;
  assign warm     = (warm_reg == `PCLK_WARMUP);

  // Edge history and warm-up count of pixel clock rising edges
  always @(posedge clock) begin
    if (!rstn) begin
      pclk_d_reg <= 1'b0;
      href_d_reg <= 1'b0;
      vref_d_reg <= 1'b0;
      warm_reg   <= 2'h0;
    end else begin
      pclk_d_reg <= s_pclk;
      if (pix_edge) begin
        href_d_reg <= s_href;
        vref_d_reg <= s_vref;
        if (!warm)
          warm_reg <= warm_reg + 2'h1;
      end
    end
  end

  // ****************************************************************
  // Embedded code path
  // ****************************************************************
  wire       cf_stb;
  wire [7:0] cf_byte;
  wire       cf_line;
  wire       code_stb;
  wire       code_v;
  wire       code_h;
  reg        v_prev_reg;

  code_finder u_codes (
    .clock    (clock),
    .rstn     (rstn),
    .enable   (embedded_mode),
    .byte_stb (pix_edge),
    .byte_in  (s_data),
    .out_stb  (cf_stb),
    .out_byte (cf_byte),
    .out_line (cf_line),
    .code_stb (code_stb),
    .code_v   (code_v),
    .code_h   (code_h)
  );

  // ****************************************************************
  // Unified byte stream and line/frame events
  // ****************************************************************
  reg        in_frame_reg;
  wire       byte_stb_u;
  wire [7:0] byte_u;
  wire       active_u;
  wire       line_end;
  wire       frame_begin;
  wire       frame_finish;

  // Pick the timing source
  assign byte_stb_u  = embedded_mode ? cf_stb : pix_edge;
  assign byte_u      = embedded_mode ? cf_byte : s_data;
  assign active_u    = embedded_mode ? cf_line : s_href;
  assign line_end    = embedded_mode ? (code_stb & code_h) :
                       (pix_edge & href_d_reg & ~s_href);
  assign frame_begin = warm & ~in_frame_reg & (embedded_mode ?
                       (code_stb & ~code_v & v_prev_reg) :
                       (pix_edge & s_vref & ~vref_d_reg));
  assign frame_finish = in_frame_reg & (embedded_mode ?
                        (code_stb & code_v) :
                        (pix_edge & vref_d_reg & ~s_vref));

  // Last seen vertical flag of the embedded codes
  always @(posedge clock) begin
    if (!rstn)
      v_prev_reg <= 1'b0;
    else if (code_stb)
      v_prev_reg <= code_v;
  end

  // ****************************************************************
  // Line position, component order and size measurement
  // ****************************************************************
  reg  [1:0]  phase_reg;
  reg  [10:0] x_reg;
  reg  [10:0] y_reg;
  reg  [9:0]  line_w_reg;
  wire        mono;
  wire        is_luma;
  wire        is_cr;
  wire        take;

  assign mono    = mono_y_only | mono_drop_chroma;
  // Default order Cb Y Cr Y; swaps move luma and pick Cr/Cb
  assign is_luma = mono_y_only | (phase_reg[0] ^ swap_luma_chroma);
  assign is_cr   = phase_reg[1] ^ swap_chroma;
  assign take    = byte_stb_u & active_u & in_frame_reg;

  // Byte phase and pixel/line counters
  always @(posedge clock) begin
    if (!rstn) begin
      phase_reg  <= 2'h0;
      x_reg      <= 11'h000;
      y_reg      <= 11'h000;
      line_w_reg <= 10'h000;
    end else if (frame_begin) begin
      phase_reg  <= 2'h0;
      x_reg      <= 11'h000;
      y_reg      <= 11'h000;
      line_w_reg <= 10'h000;
    end else if (line_end) begin
      phase_reg <= 2'h0;
      x_reg     <= 11'h000;
      if (x_reg != 11'h000) begin
        y_reg      <= (y_reg == 11'h7ff) ? y_reg : y_reg + 11'h001;
        line_w_reg <= x_reg[10] ? 10'h3ff : x_reg[9:0];
      end
    end else if (take) begin
      phase_reg <= phase_reg + 2'h1;
      if (is_luma && x_reg != 11'h7ff)
        x_reg <= x_reg + 11'h001;
    end
  end

  // ****************************************************************
  // Capture control: skip, count, stop
  // ****************************************************************
  reg  [5:0] skip_reg;
  reg        cap_reg;
  wire       allow;
  wire [5:0] total_next;

  assign allow      = capture_en & ~capture_stopped &
                      ~(limited_mode && frame_num == 6'h00);
  assign total_next = frame_total + 6'h01;

  // Frame decision at each frame start, bookkeeping at its end
  always @(posedge clock) begin
    if (!rstn) begin
      in_frame_reg    <= 1'b0;
      cap_reg         <= 1'b0;
      skip_reg        <= 6'h00;
      frame_total     <= 6'h00;
      capture_stopped <= 1'b0;
      capture_active  <= 1'b0;
      frame_start     <= 1'b0;
      frame_done      <= 1'b0;
      size_error      <= 1'b0;
    end else begin
      frame_start <= 1'b0;
      frame_done  <= 1'b0;
      if (frame_begin)
        in_frame_reg <= 1'b1;
      else if (frame_finish)
        in_frame_reg <= 1'b0;
      if (!capture_en) begin
        // Restart counting so the next enabled frame is taken
        cap_reg         <= 1'b0;
        skip_reg        <= 6'h00;
        frame_total     <= 6'h00;
        capture_stopped <= 1'b0;
        capture_active  <= 1'b0;
      end else if (frame_begin && allow) begin
        cap_reg        <= (skip_reg == 6'h00);
        capture_active <= (skip_reg == 6'h00);
        frame_start    <= (skip_reg == 6'h00);
        skip_reg       <= (skip_reg >= frame_skip) ? 6'h00 :
                          skip_reg + 6'h01;
      end else if (frame_finish && cap_reg) begin
        cap_reg        <= 1'b0;
        capture_active <= 1'b0;
        frame_done     <= 1'b1;
        frame_total    <= total_next;
        if (limited_mode && total_next >= frame_num)
          capture_stopped <= 1'b1;
        size_error <= ~size_ok(line_w_reg, y_reg[10] ? 10'h3ff :
                      y_reg[9:0], scaler_en);
      end
    end
  end

  // ****************************************************************
  // Pixel output with crop and monochrome filtering
  // ****************************************************************
  wire in_crop;
  wire keep_byte;

  assign in_crop   = in_window(x_reg, crop_x, crop_w, `FRAME_MAX_W) &&
                     in_window(y_reg, crop_y, crop_h, `FRAME_MAX_H);
  assign keep_byte = take & cap_reg & in_crop &
                     ~(mono & ~is_luma);

  // Registered output byte and its component tag
  always @(posedge clock) begin
    if (!rstn) begin
      pix_out   <= 8'h00;
      pix_valid <= 1'b0;
      pix_comp  <= `COMP_Y;
    end else begin
      pix_valid <= keep_byte;
      if (keep_byte) begin
        pix_out <= byte_u;
        if (is_luma)
          pix_comp <= `COMP_Y;
        else if (is_cr)
          pix_comp <= `COMP_CR;
        else
          pix_comp <= `COMP_CB;
      end
    end
  end

endmodule // sensor_capture

// ==== test/sensor_capture_monitor.sv ====
// Checker of the sensor capture front end, bound to its top module.
// Assumes one clock domain and the synchronous active-low reset rstn.
`include "capture_regs.vh"
module sensor_capture_monitor (
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic       pix_clk,
  input wire logic       capture_en,
  input wire logic       mono_y_only,
  input wire logic       mono_drop_chroma,
  input wire logic [5:0] frame_num,
  input wire logic       pix_valid,
  input wire logic [1:0] pix_comp,
  input wire logic       frame_start,
  input wire logic       frame_done,
  input wire logic       capture_active,
  input wire logic       capture_stopped,
  input wire logic [5:0] frame_total
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // Helper logic
  // ********
  logic       pclk_q;
  logic [1:0] rises;
  // Saturating count of pixel clock rises since reset
  always @(posedge clock) begin
    if (!rstn) begin
      pclk_q <= 1'b0;
      rises  <= 2'h0;
    end else begin
      pclk_q <= pix_clk;
      if (pix_clk && !pclk_q && rises != 2'h3)
        rises <= rises + 2'h1;
    end
  end
  // ********
  // Assertions
  // ********
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_valid_active; pix_valid |-> capture_active; endproperty
  a_valid_active: assert property (p_valid_active)
    else $error("byte outside a captured frame");
  property p_mono_luma;
    pix_valid && (mono_y_only || mono_drop_chroma) |-> pix_comp == `COMP_Y;
  endproperty
  a_mono_luma: assert property (p_mono_luma)
    else $error("chroma byte in a monochrome mode");
  property p_stop_quiet;
    capture_stopped |-> !pix_valid && !frame_start;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet)
    else $error("capture after stop");
  property p_stop_count; capture_stopped |-> frame_total == frame_num;
  endproperty
  a_stop_count: assert property (p_stop_count)
    else $error("stopped at wrong frame count");
  property p_done_inc;
    frame_done |-> frame_total == $past(frame_total) + 6'h01;
  endproperty
  a_done_inc: assert property (p_done_inc)
    else $error("frame count not advanced at frame end");
  property p_total_hold;
    $changed(frame_total) |-> frame_done || !$past(capture_en);
  endproperty
  a_total_hold: assert property (p_total_hold)
    else $error("frame count moved without a frame end");
  property p_en_clear;
    !capture_en |=> frame_total == 6'h00 && !capture_stopped;
  endproperty
  a_en_clear: assert property (p_en_clear)
    else $error("count or stop not cleared while disabled");
  property p_valid_gap; pix_valid |=> !pix_valid [*3]; endproperty
  a_valid_gap: assert property (p_valid_gap)
    else $error("two bytes from one pixel clock rise");
  property p_warmup; frame_start |-> rises == 2'h3; endproperty
  a_warmup: assert property (p_warmup)
    else $error("frame start before pixel clock warm-up");
  c_done: cover property (frame_done);
  c_stop: cover property ($rose(capture_stopped));
  c_cr: cover property (pix_valid && pix_comp == `COMP_CR);
endmodule // sensor_capture_monitor

// ==== test/sensor_model.sv ====
// Image sensor model: pixel clock, 8-bit data and reference pins.
// Assumes the bench fills pix_q with every active byte of the next frame.
module sensor_model (
  output logic       pix_clk,
  output logic [7:0] pix_data,
  output logic       href,
  output logic       vref
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] pix_q[$];
  // ********
  // Pin drivers
  // ********
  // Clock stands still low outside frames
  initial begin
    pix_clk  = 1'b0;
    pix_data = 8'h5a;
    href     = 1'b0;
    vref     = 1'b0;
  end
  // One 800 ns pixel clock period, pins change while the clock is low
  task automatic tick(input logic [7:0] d, input logic h, input logic v);
    pix_data = d;
    href     = h;
    vref     = v;
    #400 pix_clk = 1'b1;
    #400 pix_clk = 1'b0;
  endtask
  // Four-byte timing code, flag byte last
  task automatic code(input logic [7:0] xy);
    tick(8'hff, 1'b0, 1'b0);
    repeat (2) tick(8'h00, 1'b0, 1'b0);
    tick(xy, 1'b0, 1'b0);
  endtask
  // One progressive frame of h lines, nb bytes a line
  task automatic frame(input int nb, input int h, input int pre,
                       input logic emb);
    #37;
    repeat (pre) tick(~pix_data, 1'b0, 1'b0);
    if (emb) code(8'hb0);
    for (int y = 0; y < h; y++) begin
      if (emb) code(8'h8e);
      else repeat (2) tick(~pix_data, 1'b0, 1'b1);
      repeat (nb) tick(pix_q.pop_front(), !emb, !emb);
      if (emb) code(8'h9d);
      else tick(~pix_data, 1'b0, 1'b1);
    end
    if (emb) code(8'hf1);
    repeat (3) tick(emb ? 8'h10 : ~pix_data, 1'b0, 1'b0);
  endtask
endmodule // sensor_model

// ==== test/sensor_capture_bench.sv ====
// Self-checking bench of the sensor capture front end.
// Assumes capture_regs.vh on the include path and the sensor model.
`include "capture_regs.vh"
module sensor_capture_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, rstn, capture_en, embedded_mode, scaler_en;
  logic        swap_chroma, swap_luma_chroma, mono_y_only;
  logic        mono_drop_chroma, limited_mode;
  logic [5:0]  frame_num, frame_skip;
  logic [9:0]  crop_x, crop_w, crop_y, crop_h, ex;
  wire         pix_clk, href, vref, pix_valid, frame_start, frame_done;
  wire         capture_active, capture_stopped, size_error;
  wire  [7:0]  pix_data, pix_out;
  wire  [1:0]  pix_comp;
  wire  [5:0]  frame_total;
  int          mismatches, samples_checked, skip_cnt, total;
  int          starts, dones, starts_seen, dones_seen;
  logic [31:0] lfsr_reg;
  logic [9:0]  exp_q[$];
  logic [7:0]  modes[10] = '{8'h00, 8'h10, 8'h08, 8'h38, 8'h04, 8'h02,
                             8'h40, 8'h58, 8'h44, 8'h42};
  // ********
  // Design, sensor and clock
  // ********
  sensor_capture DUT (
    .clock, .rstn, .pix_clk, .pix_data, .href, .vref, .capture_en,
    .embedded_mode, .scaler_en, .swap_chroma, .swap_luma_chroma,
    .mono_y_only, .mono_drop_chroma, .limited_mode, .frame_num,
    .frame_skip, .crop_x, .crop_w, .crop_y, .crop_h, .pix_out, .pix_valid,
    .pix_comp, .frame_start, .frame_done, .capture_active,
    .capture_stopped, .frame_total, .size_error
  );
  sensor_model u_sensor (.pix_clk, .pix_data, .href, .vref);
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // ********
  // Checking
  // ********
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], ^(s & 32'h80200003)};
  endfunction
  task automatic check(input string name, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Output bytes against the queue of expected ones, and pulse counts
  always @(posedge clock) begin
    if (rstn === 1'b1) begin
      if (frame_start === 1'b1) starts_seen++;
      if (frame_done === 1'b1) dones_seen++;
      if (pix_valid === 1'b1 && exp_q.size() == 0)
        check("extra_byte", 1, 0);
      else if (pix_valid === 1'b1) begin
        ex = exp_q.pop_front();
        check("pix_out", pix_out, ex[7:0]);
        check("pix_comp", pix_comp, ex[9:8]);
        check("active", capture_active, 1);
      end
    end
  end
  // ********
  // Stimulus
  // ********
  // Re-enable with a new mode byte: emb scaler swaps mono limited
  task automatic setup(input logic [7:0] m, input logic [5:0] num, skip);
    @(posedge clock);
    capture_en <= 1'b0;
    repeat (2) @(posedge clock);
    {embedded_mode, scaler_en, swap_chroma, swap_luma_chroma} <= m[6:3];
    {mono_y_only, mono_drop_chroma, limited_mode} <= m[2:0];
    frame_num <= num;
    frame_skip <= skip;
    @(posedge clock);
    capture_en <= 1'b1;
    repeat (2) @(posedge clock);
    {skip_cnt, total, starts, dones, starts_seen, dones_seen} = '0;
    check("total_clear", frame_total, 0);
    check("stop_clear", capture_stopped, 0);
  endtask
  // Send one frame of w pixels by h lines and predict the output
  task automatic run_frame(input int w, h, pre, input logic cnt);
    int nb, x;
    logic [7:0] d;
    logic take, luma, first;
    nb = mono_y_only ? w : 2 * w;
    take = cnt && skip_cnt == 0 && !(limited_mode && total >= frame_num);
    for (int y = 0; y < h; y++) begin
      x = 0;
      for (int i = 0; i < nb; i++) begin
        lfsr_reg = lfsr_next(lfsr_reg);
        d = lfsr_reg[7:0];
        if (d == 8'hff || d == 8'h00) d = 8'h5a;
        u_sensor.pix_q.push_back(d);
        luma = mono_y_only || i[0] != swap_luma_chroma;
        first = i[1:0] == {1'b0, swap_luma_chroma};
        if (take && x >= crop_x && x < crop_x + crop_w && y >= crop_y &&
            y < crop_y + crop_h && (luma || !mono_drop_chroma))
          exp_q.push_back({luma ? `COMP_Y :
                           first != swap_chroma ? `COMP_CB : `COMP_CR, d});
        if (luma) x++;
      end
    end
    u_sensor.frame(nb, h, pre, embedded_mode);
    repeat (30) @(posedge clock);
    if (take) {total, starts, dones} = {total + 1, starts + 1, dones + 1};
    if (cnt) skip_cnt = skip_cnt >= frame_skip ? 0 : skip_cnt + 1;
    check("bytes_left", exp_q.size(), 0);
    exp_q.delete();
    check("frame_total", frame_total, total);
    check("starts", starts_seen, starts);
    check("dones", dones_seen, dones);
    if (take) check("size_error", size_error, 1);
  endtask
  // Main sequence
  initial begin
    {rstn, capture_en, embedded_mode, scaler_en, swap_chroma} = '0;
    {swap_luma_chroma, mono_y_only, mono_drop_chroma, limited_mode} = '0;
    {frame_num, frame_skip, crop_x, crop_y} = '0;
    crop_w = 10'h280;
    crop_h = 10'h1e0;
    lfsr_reg = 32'hb06f5538;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    setup(8'h00, 6'h00, 6'h00);
    run_frame(4, 2, 0, 1'b0);
    foreach (modes[i]) begin
      setup(modes[i], 6'h00, 6'h00);
      run_frame(4 + 2 * (lfsr_reg % 3), 3, 4, 1'b1);
    end
    setup(8'h00, 6'h00, 6'h02);
    repeat (7) run_frame(4, 2, 2, 1'b1);
    setup(8'h41, 6'h02, 6'h01);
    repeat (6) run_frame(4, 2, 2, 1'b1);
    check("stopped", capture_stopped, 1);
    // Limited mode with a zero count captures nothing and never stops
    setup(8'h01, 6'h00, 6'h00);
    run_frame(4, 2, 2, 1'b1);
    check("none_stop", capture_stopped, 0);
    {crop_x, crop_w, crop_y, crop_h} <= {10'h2, 10'h2, 10'h1, 10'h1};
    setup(8'h00, 6'h00, 6'h00);
    run_frame(8, 3, 2, 1'b1);
    setup(8'h08, 6'h00, 6'h00);
    run_frame(8, 3, 2, 1'b1);
    report_and_stop();
  end
  // Watchdog: about five to six times the expected run
  initial begin
    #6000000;
    mismatches++;
    report_and_stop();
  end
endmodule // sensor_capture_bench

bind sensor_capture sensor_capture_monitor u_monitor (
  .clock, .rstn, .pix_clk, .capture_en, .mono_y_only, .mono_drop_chroma,
  .frame_num, .pix_valid, .pix_comp, .frame_start, .frame_done,
  .capture_active, .capture_stopped, .frame_total
);
